// >>> rtl/eaa_adder.sv
`timescale 1ns/100ps
`include "eaa_params.svh"

module eaa_adder (
   // Operands
   input wire logic [`EAA_XLEN-1:0] opa,
   input wire logic [`EAA_XLEN-1:0] opb,
   input wire logic cin,
   input wire logic mode32,
   // Results
   output logic [`EAA_XLEN-1:0] sum,
   output logic cout,
   output logic ovf
);

   logic [`EAA_XLEN:0] full;
   logic [`EAA_HALF:0] low;
   logic ovf_full;
   logic ovf_low;

   // ****************************************
   // Full and low-word sums
   // ****************************************
   // The low word is summed apart so its carry is exact in 32-bit mode.
   assign full = {1'b0, opa} + {1'b0, opb} + {{`EAA_XLEN{1'b0}}, cin};
   assign low = {1'b0, opa[`EAA_HALF-1:0]} + {1'b0, opb[`EAA_HALF-1:0]} +
                {{`EAA_HALF{1'b0}}, cin};
   assign sum = full[`EAA_XLEN-1:0];
   assign cout = mode32 ? low[`EAA_HALF] : full[`EAA_XLEN];  // [RL10]
   assign ovf_full = (opa[`EAA_XLEN-1] == opb[`EAA_XLEN-1]) &&
                     (full[`EAA_XLEN-1] != opa[`EAA_XLEN-1]);
   assign ovf_low = (opa[`EAA_HALF-1] == opb[`EAA_HALF-1]) &&
                    (low[`EAA_HALF-1] != opa[`EAA_HALF-1]);
   assign ovf = mode32 ? ovf_low : ovf_full;  // [RL11]

endmodule

// >>> rtl/eaa_alu.sv
`timescale 1ns/100ps
`include "eaa_params.svh"

// Overview of operation
// RL1: Add extended writes first plus second source plus carry bit.
// RL2: Subtract extended writes complemented first plus second source plus carry.
// RL3: Add minus one writes first source plus carry plus all ones.
// RL4: Subtract minus one writes complemented first plus carry plus all ones.
// RL5: Add to zero writes first source plus carry.
// RL6: Subtract to zero writes complemented first source plus carry.
// RL7: Negate writes complemented first source plus one.
// RL8: Record form updates compare field; other forms leave flags untouched.
// RL9: Overflow form enables overflow bit update; others leave it untouched.
// RL10: Carry bit takes carry out of the top, or of the low word in 32-bit mode.
// RL11: Overflow and sticky bits follow overflow of 64-bit or low 32-bit result.
// RL12: Updated flags describe the value actually written to the destination.
// RL13: Compare field encodes negative, positive, zero and copies sticky bit.
module eaa_alu (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Operation issue
   input wire logic op_valid,
   input wire eaa_pkg::eaa_op_e op_code,
   input wire logic op_rec,
   input wire logic op_ovf_en,
   input wire logic [`EAA_RIDX_W-1:0] op_dst,
   input wire logic [`EAA_RIDX_W-1:0] op_src1,
   input wire logic [`EAA_RIDX_W-1:0] op_src2,
   // Operation result
   output logic res_valid,
   output logic [`EAA_XLEN-1:0] res_data,
   // Register port
   input wire logic [`EAA_ADDR_W-1:0] reg_addr,
   input wire logic [`EAA_XLEN-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`EAA_XLEN-1:0] reg_rdata,
   // Interrupt
   output logic irq
);

   // ****************************************
   // Storage
   // ****************************************
   eaa_pkg::eaa_word_t gpr_r [`EAA_NREG];
   logic [31:0] fixed_point_exception_reg_r;
   logic [31:0] condition_flags_r;
   logic mode32_r;
   logic [`EAA_IRQ_W-1:0] stat_r;
   logic [`EAA_IRQ_W-1:0] mask_r;
   logic [`EAA_XLEN-1:0] rdata_r;
   logic res_valid_r;
   logic [`EAA_XLEN-1:0] res_data_r;

   // ****************************************
   // Operand selection
   // ****************************************
   eaa_pkg::eaa_word_t first_src_reg;
   eaa_pkg::eaa_word_t second_src_reg;
   logic [`EAA_XLEN-1:0] opa_x;
   logic [`EAA_XLEN-1:0] opb_x;
   logic cin_x;
   logic [`EAA_XLEN-1:0] sum_w;
   logic cout_w;
   logic ovf_w;
   logic sum_cout_bit;
   logic sticky_excess_bit;

   assign first_src_reg = gpr_r[op_src1];
   assign second_src_reg = gpr_r[op_src2];
   assign sum_cout_bit = fixed_point_exception_reg_r[`EAA_FXE_CARRY];
   assign sticky_excess_bit = fixed_point_exception_reg_r[`EAA_FXE_SO];

   always_comb begin
      opa_x = first_src_reg;
      opb_x = {`EAA_XLEN{1'b0}};
      cin_x = sum_cout_bit;
      unique case (op_code)
         eaa_pkg::EAA_OP_ADDE: begin
            opb_x = second_src_reg;  // [RL1]
         end
         eaa_pkg::EAA_OP_SUBFE: begin
            opa_x = ~first_src_reg;  // [RL2]
            opb_x = second_src_reg;
         end
         eaa_pkg::EAA_OP_ADDME: begin
            opb_x = {`EAA_XLEN{1'b1}};  // [RL3]
         end
         eaa_pkg::EAA_OP_SUBFME: begin
            opa_x = ~first_src_reg;  // [RL4]
            opb_x = {`EAA_XLEN{1'b1}};
         end
         eaa_pkg::EAA_OP_ADDZE: begin
            opa_x = first_src_reg;  // [RL5]
         end
         eaa_pkg::EAA_OP_SUBFZE: begin
            opa_x = ~first_src_reg;  // [RL6]
         end
         eaa_pkg::EAA_OP_NEG: begin
            opa_x = ~first_src_reg;  // [RL7]
            cin_x = 1'b1;
         end
         default: begin
            opa_x = first_src_reg;
         end
      endcase
   end

   eaa_adder u_adder (
      .opa(opa_x),
      .opb(opb_x),
      .cin(cin_x),
      .mode32(mode32_r),
      .sum(sum_w),
      .cout(cout_w),
      .ovf(ovf_w)
   );

   // ****************************************
   // Flag derivation
   // ****************************************
   // The compare field is taken from the sum itself, so it describes the value
   // that lands in the destination register, only its low word in 32-bit mode.
   logic so_new;
   logic res_neg;
   logic res_zero;
   logic [3:0] result_compare_field;

   assign so_new = sticky_excess_bit | (op_ovf_en & ovf_w);  // [RL11]
   assign res_neg = mode32_r ? sum_w[`EAA_HALF-1] : sum_w[`EAA_XLEN-1];  // [RL12]
   assign res_zero = mode32_r ? (sum_w[`EAA_HALF-1:0] == 32'h00000000) :
                     (sum_w == 64'h0000000000000000);
   assign result_compare_field = {res_neg, ~res_neg & ~res_zero, res_zero, so_new};  // [RL13]

   // ****************************************
   // Register port decode
   // ****************************************
   logic op_go;
   logic wr_gpr;
   logic wr_fxe;
   logic wr_cnd;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic [`EAA_IRQ_W-1:0] ev_w;

   assign op_go = op_valid;
   assign wr_gpr = reg_wr && (reg_addr <= `EAA_OFS_GPR_LAST);
   assign wr_fxe = reg_wr && (reg_addr == `EAA_OFS_FXE);
   assign wr_cnd = reg_wr && (reg_addr == `EAA_OFS_CND);
   assign wr_ctrl = reg_wr && (reg_addr == `EAA_OFS_CTRL);
   assign wr_stat = reg_wr && (reg_addr == `EAA_OFS_STAT);
   assign wr_mask = reg_wr && (reg_addr == `EAA_OFS_MASK);
   assign ev_w[`EAA_IRQ_OVF] = op_go & op_ovf_en & ovf_w;
   assign ev_w[`EAA_IRQ_DONE] = op_go;

   // ****************************************
   // General register file
   // ****************************************
   // An issued operation beats a software write to the same entry.
   for (genvar gi = 0; gi < `EAA_NREG; gi++) begin : g_gpr
      always_ff @(posedge core_clk or posedge sys_rst) begin
         if (sys_rst) begin
            gpr_r[gi] <= `EAA_GPR_RST;
         end else if (op_go && (op_dst == 5'(gi))) begin
            gpr_r[gi] <= sum_w;  // [RL12]
         end else if (wr_gpr && (reg_addr[`EAA_RIDX_W-1:0] == 5'(gi))) begin
            gpr_r[gi] <= reg_wdata;
         end
      end
   end

   // ****************************************
   // Exception register
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fixed_point_exception_reg_r <= `EAA_FXE_RST;
      end else if (op_go) begin
         fixed_point_exception_reg_r[`EAA_FXE_CARRY] <= cout_w;  // [RL10]
         if (op_ovf_en) begin
            fixed_point_exception_reg_r[`EAA_FXE_OVF] <= ovf_w;  // [RL9]
            fixed_point_exception_reg_r[`EAA_FXE_SO] <= so_new;  // [RL11]
         end
      end else if (wr_fxe) begin
         fixed_point_exception_reg_r <= reg_wdata[31:0] & `EAA_FXE_MASK;
      end
   end

   // ****************************************
   // Condition flags
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         condition_flags_r <= `EAA_CND_RST;
      end else if (op_go && op_rec) begin
         condition_flags_r[`EAA_CMP_HI:`EAA_CMP_LO] <= result_compare_field;  // [RL8]
      end else if (wr_cnd) begin
         condition_flags_r <= reg_wdata[31:0];
      end
   end

   // ****************************************
   // Control, status and mask
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode32_r <= `EAA_CTRL_RST;
         mask_r <= `EAA_IRQ_RST;
      end else begin
         if (wr_ctrl) begin
            mode32_r <= reg_wdata[`EAA_CTRL_MODE32];
         end
         if (wr_mask) begin
            mask_r <= reg_wdata[`EAA_IRQ_W-1:0];
         end
      end
   end

   // A new event in the clearing cycle survives: set wins over clear.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_r <= `EAA_IRQ_RST;
      end else begin
         stat_r <= (stat_r & ~(wr_stat ? reg_wdata[`EAA_IRQ_W-1:0] : `EAA_IRQ_RST)) | ev_w;
      end
   end

   assign irq = |(stat_r & mask_r);

   // ****************************************
   // Read data and result
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= `EAA_GPR_RST;
      end else if (reg_rd) begin
         if (reg_addr <= `EAA_OFS_GPR_LAST) begin
            rdata_r <= gpr_r[reg_addr[`EAA_RIDX_W-1:0]];
         end else begin
            unique case (reg_addr)
               `EAA_OFS_FXE: rdata_r <= {32'h00000000, fixed_point_exception_reg_r};
               `EAA_OFS_CND: rdata_r <= {32'h00000000, condition_flags_r};
               `EAA_OFS_CTRL: rdata_r <= {63'h0, mode32_r};
               `EAA_OFS_STAT: rdata_r <= {62'h0, stat_r};
               `EAA_OFS_MASK: rdata_r <= {62'h0, mask_r};
               default: rdata_r <= `EAA_GPR_RST;
            endcase
         end
      end else begin
         rdata_r <= `EAA_GPR_RST;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         res_valid_r <= 1'b0;
         res_data_r <= `EAA_GPR_RST;
      end else begin
         res_valid_r <= op_go;
         if (op_go) begin
            res_data_r <= sum_w;
         end
      end
   end

   assign reg_rdata = rdata_r;
   assign res_valid = res_valid_r;
   assign res_data = res_data_r;

   // ****************************************
   // Checks
   // ****************************************
   // The low-word carry is recomputed here apart from the adder instance.
   logic [`EAA_HALF:0] chk_lo;
   assign chk_lo = {1'b0, opa_x[`EAA_HALF-1:0]} + {1'b0, opb_x[`EAA_HALF-1:0]} +
                   {32'h00000000, cin_x};

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_issue(eaa_pkg::eaa_op_e k);
      op_valid && (op_code == k);
   endsequence

   sequence s_rec_op;
      op_valid && op_rec;
   endsequence

   property p_adde;
      s_issue(eaa_pkg::EAA_OP_ADDE) |=> gpr_r[$past(op_dst)] ==
         $past(first_src_reg) + $past(second_src_reg) + {63'h0, $past(sum_cout_bit)};
   endproperty
   a_adde: assert property (p_adde) else $error("add extended result wrong"); // [RL1]

   property p_subfe;
      s_issue(eaa_pkg::EAA_OP_SUBFE) |=> gpr_r[$past(op_dst)] ==
         ~$past(first_src_reg) + $past(second_src_reg) + {63'h0, $past(sum_cout_bit)};
   endproperty
   a_subfe: assert property (p_subfe) else $error("subtract extended result wrong"); // [RL2]

   property p_addme;
      s_issue(eaa_pkg::EAA_OP_ADDME) |=> res_data ==
         $past(first_src_reg) + {63'h0, $past(sum_cout_bit)} + 64'hffffffffffffffff;
   endproperty
   a_addme: assert property (p_addme) else $error("add minus one result wrong"); // [RL3]

   property p_subfme;
      s_issue(eaa_pkg::EAA_OP_SUBFME) |=> res_data ==
         ~$past(first_src_reg) + {63'h0, $past(sum_cout_bit)} + 64'hffffffffffffffff;
   endproperty
   a_subfme: assert property (p_subfme) else $error("subtract minus one wrong"); // [RL4]

   property p_addze;
      s_issue(eaa_pkg::EAA_OP_ADDZE) |=> res_valid &&
         (res_data == $past(first_src_reg) + {63'h0, $past(sum_cout_bit)});
   endproperty
   a_addze: assert property (p_addze) else $error("add to zero result wrong"); // [RL5]

   property p_subfze;
      s_issue(eaa_pkg::EAA_OP_SUBFZE) |=> res_valid &&
         (res_data == ~$past(first_src_reg) + {63'h0, $past(sum_cout_bit)});
   endproperty
   a_subfze: assert property (p_subfze) else $error("subtract to zero wrong"); // [RL6]

   property p_neg;
      s_issue(eaa_pkg::EAA_OP_NEG) |=> gpr_r[$past(op_dst)] ==
         64'h0000000000000000 - $past(first_src_reg);
   endproperty
   a_neg: assert property (p_neg) else $error("negate result wrong"); // [RL7]

   property p_norec;
      op_valid && !op_rec && !wr_cnd |=> $stable(condition_flags_r);
   endproperty
   a_norec: assert property (p_norec) else $error("flags changed without record"); // [RL8]

   property p_noovf;
      op_valid && !op_ovf_en |=>
         $stable(fixed_point_exception_reg_r[`EAA_FXE_SO:`EAA_FXE_OVF]);
   endproperty
   a_noovf: assert property (p_noovf) else $error("overflow bits changed"); // [RL9]

   property p_carry32;
      op_valid && mode32_r |=> sum_cout_bit == $past(chk_lo[`EAA_HALF]);
   endproperty
   a_carry32: assert property (p_carry32) else $error("32-bit carry wrong"); // [RL10]

   property p_ovf64;
      op_valid && op_ovf_en && !mode32_r && (opa_x[63] == opb_x[63]) &&
         (sum_w[63] != opa_x[63]) |=>
         fixed_point_exception_reg_r[`EAA_FXE_OVF] && sticky_excess_bit ##1
         sticky_excess_bit || $past(wr_fxe);
   endproperty
   a_ovf64: assert property (p_ovf64) else $error("overflow not recorded"); // [RL11]

   property p_cmp_desc;
      s_rec_op |=> condition_flags_r[`EAA_CMP_EQ] ==
         ($past(mode32_r) ? (res_data[31:0] == 32'h00000000) :
         (res_data == 64'h0000000000000000));
   endproperty
   a_cmp_desc: assert property (p_cmp_desc) else $error("zero flag mismatch"); // [RL12]

   property p_cmp_so;
      s_rec_op |=> (condition_flags_r[`EAA_CMP_SO] == sticky_excess_bit) &&
         ($countones(condition_flags_r[`EAA_CMP_HI:`EAA_CMP_EQ]) == 1);
   endproperty
   a_cmp_so: assert property (p_cmp_so) else $error("compare field malformed"); // [RL13]

endmodule

// >>> rtl/eaa_params.svh
`ifndef EAA_PARAMS_SVH
`define EAA_PARAMS_SVH

// ****************************************
// Datapath widths
// ****************************************
`define EAA_XLEN 64
`define EAA_HALF 32
`define EAA_NREG 32
`define EAA_RIDX_W 5
`define EAA_ADDR_W 6

// ****************************************
// Register port offsets
// ****************************************
`define EAA_OFS_GPR_LAST 6'h1f
`define EAA_OFS_FXE 6'h20
`define EAA_OFS_CND 6'h21
`define EAA_OFS_CTRL 6'h22
`define EAA_OFS_STAT 6'h23
`define EAA_OFS_MASK 6'h24

// ****************************************
// Field positions
// ****************************************
`define EAA_FXE_SO 31
`define EAA_FXE_OVF 30
`define EAA_FXE_CARRY 29
`define EAA_FXE_MASK 32'he0000000
`define EAA_CMP_HI 31
`define EAA_CMP_LO 28
`define EAA_CMP_EQ 29
`define EAA_CMP_SO 28
`define EAA_CTRL_MODE32 0
`define EAA_IRQ_OVF 0
`define EAA_IRQ_DONE 1
`define EAA_IRQ_W 2

// ****************************************
// Reset values
// ****************************************
`define EAA_FXE_RST 32'h00000000
`define EAA_CND_RST 32'h00000000
`define EAA_CTRL_RST 1'h0
`define EAA_IRQ_RST 2'h0
`define EAA_GPR_RST 64'h0000000000000000

`endif

// >>> rtl/eaa_pkg.sv
package eaa_pkg;

   // ****************************************
   // Operation codes and data types
   // ****************************************
   typedef enum logic [2:0] {
      EAA_OP_ADDE,
      EAA_OP_SUBFE,
      EAA_OP_ADDME,
      EAA_OP_SUBFME,
      EAA_OP_ADDZE,
      EAA_OP_SUBFZE,
      EAA_OP_NEG
   } eaa_op_e;

   typedef logic [63:0] eaa_word_t;

endpackage

// >>> tb/eaa_alu_test.sv
`timescale 1ns/100ps
`include "eaa_params.svh"

module eaa_alu_test;
   // ****************************************
   // Design hookup
   // ****************************************
   logic core_clk, sys_rst, op_valid, op_rec, op_ovf_en, reg_wr, reg_rd, res_valid, irq, took;
   eaa_pkg::eaa_op_e op_code;
   logic [4:0] op_dst, op_src1, op_src2;
   logic [5:0] reg_addr;
   logic [63:0] reg_wdata, res_data, reg_rdata;
   logic [63:0] m_gpr [32];
   logic [63:0] exp_q [$];
   logic m_carry, m_ovf, m_so, m_mode;
   logic [3:0] m_cmp;
   logic [1:0] m_stat, m_mask;
   int bad_count, n_tests;

   eaa_alu eaa_alu_i (.core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid),
      .op_code(op_code), .op_rec(op_rec), .op_ovf_en(op_ovf_en), .op_dst(op_dst),
      .op_src1(op_src1), .op_src2(op_src2), .res_valid(res_valid), .res_data(res_data),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));

   initial begin
      core_clk = 1'h0;
      forever #20 core_clk = ~core_clk;
   end

   // ****************************************
   // Checking helpers
   // ****************************************
   task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task give_verdict;
      if (bad_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   function logic [63:0] reg_exp(input logic [5:0] a);
      if (a <= `EAA_OFS_GPR_LAST) return m_gpr[a[4:0]];
      case (a)
         `EAA_OFS_FXE: return {32'h0, m_so, m_ovf, m_carry, 29'h0};
         `EAA_OFS_CND: return {32'h0, m_cmp, 28'h0};
         `EAA_OFS_CTRL: return {63'h0, m_mode};
         `EAA_OFS_STAT: return {62'h0, m_stat};
         `EAA_OFS_MASK: return {62'h0, m_mask};
         default: return 64'h0;
      endcase
   endfunction

   // ****************************************
   // Register port and operation drivers
   // ****************************************
   task wr(input logic [5:0] a, input logic [63:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      if (a <= `EAA_OFS_GPR_LAST) m_gpr[a[4:0]] = d;
      else if (a == `EAA_OFS_FXE) {m_so, m_ovf, m_carry} = d[31:29];
      else if (a == `EAA_OFS_CND) m_cmp = d[31:28];
      else if (a == `EAA_OFS_CTRL) m_mode = d[0];
      else if (a == `EAA_OFS_STAT) m_stat = m_stat & ~d[1:0];
      else if (a == `EAA_OFS_MASK) m_mask = d[1:0];
      @(posedge core_clk);
      reg_wr <= 1'h0;
      @(posedge core_clk);
   endtask

   // The compare field is the only part of the condition word this block owns.
   task rd(input logic [5:0] a);
      logic [63:0] m;
      m = (a == `EAA_OFS_CND) ? 64'hf0000000 : 64'hffffffffffffffff;
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      @(negedge core_clk);
      chk("reg_rdata", reg_rdata & m, reg_exp(a));
      chk("irq", {63'h0, irq}, {63'h0, |(m_stat & m_mask)});
      @(negedge core_clk);
      chk("reg_rdata idle", reg_rdata, 64'h0);
      @(posedge core_clk);
   endtask

   task do_op(input int code, input logic rec, input logic ovf_en, input logic [4:0] d,
              input logic [4:0] s1, input logic [4:0] s2);
      logic [63:0] x, y, r;
      logic signed [63:0] v;
      logic [64:0] full;
      logic [32:0] lo;
      logic c, ofl;
      x = m_gpr[s1];
      y = 64'h0;
      c = m_carry;
      if (code inside {1, 3, 5, 6}) x = ~x;
      if (code inside {0, 1}) y = m_gpr[s2];
      if (code inside {2, 3}) y = 64'hffffffffffffffff;
      if (code == 6) c = 1'h1;
      full = {1'h0, x} + {1'h0, y} + 65'(c);
      lo = {1'h0, x[31:0]} + {1'h0, y[31:0]} + 33'(c);
      r = full[63:0];
      ofl = m_mode ? (x[31] == y[31]) && (r[31] != x[31]) : (x[63] == y[63]) && (r[63] != x[63]);
      v = m_mode ? {{32{r[31]}}, r[31:0]} : r;
      m_carry = m_mode ? lo[32] : full[64];
      if (ovf_en) begin
         m_ovf = ofl;
         m_so = m_so | ofl;
         m_stat[0] = m_stat[0] | ofl;
      end
      if (rec) m_cmp = {v < 0, v > 0, v == 0, m_so};
      m_stat[1] = 1'h1;
      m_gpr[d] = r;
      exp_q.push_back(r);
      op_code <= eaa_pkg::eaa_op_e'(code);
      op_rec <= rec;
      op_ovf_en <= ovf_en;
      op_dst <= d;
      op_src1 <= s1;
      op_src2 <= s2;
      op_valid <= 1'h1;
      @(posedge core_clk);
   endtask

   task idle(input int n);
      op_valid <= 1'h0;
      repeat (n) @(posedge core_clk);
   endtask

   task corner(input logic [63:0] a, input logic [63:0] b, input logic cy, input logic md,
               input int code, input logic rec, input logic ovf_en);
      wr(6'h01, a);
      wr(6'h02, b);
      wr(`EAA_OFS_FXE, {34'h0, cy, 29'h0});
      wr(`EAA_OFS_CTRL, {63'h0, md});
      do_op(code, rec, ovf_en, 5'h03, 5'h01, 5'h02);
      idle(1);
      rd(`EAA_OFS_FXE);
      rd(`EAA_OFS_CND);
      rd(6'h03);
   endtask

   // ****************************************
   // Result monitor
   // ****************************************
   always @(posedge core_clk) took <= op_valid & ~sys_rst;

   always @(negedge core_clk) begin
      if (!sys_rst) begin
         chk("res_valid", {63'h0, res_valid}, {63'h0, took});
         if (took === 1'h1) begin
            chk("res_data", res_data, exp_q.pop_front());
         end
      end
   end

   // ****************************************
   // Watchdog
   // ****************************************
   initial begin
      #(40 * 20000);
      bad_count++;
      give_verdict;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      sys_rst = 1'h1;
      {op_valid, op_rec, op_ovf_en, reg_wr, reg_rd} = 5'h00;
      op_code = eaa_pkg::EAA_OP_ADDE;
      {op_dst, op_src1, op_src2} = 15'h0000;
      reg_addr = 6'h00;
      reg_wdata = 64'h0;
      {m_carry, m_ovf, m_so, m_mode, m_cmp, m_stat, m_mask} = 12'h000;
      foreach (m_gpr[i]) m_gpr[i] = 64'h0;
      bad_count = 0;
      n_tests = 0;
      void'($urandom(22144));
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'h0;
      rd(6'h00);
      for (int i = 31; i < 38; i++) rd(6'(i));
      // Unmapped places ignore writes and read as zero.
      wr(6'h25, 64'hffffffffffffffff);
      wr(6'h3f, 64'hffffffffffffffff);
      rd(6'h25);
      rd(6'h3f);
      corner(64'h7fffffffffffffff, 64'h0000000000000000, 1'h1, 1'h0, 0, 1'h1, 1'h1);
      corner(64'h8000000000000000, 64'h0, 1'h0, 1'h0, 6, 1'h1, 1'h1);
      corner(64'h0, 64'h0, 1'h0, 1'h0, 2, 1'h1, 1'h0);
      corner(64'hffffffffffffffff, 64'h0, 1'h1, 1'h0, 5, 1'h1, 1'h1);
      corner(64'h000000007fffffff, 64'h0, 1'h1, 1'h1, 4, 1'h1, 1'h1);
      corner(64'h00000000ffffffff, 64'h1, 1'h0, 1'h1, 0, 1'h1, 1'h0);
      // Interrupt masking and write-one-to-clear.
      wr(`EAA_OFS_MASK, 64'h0);
      rd(`EAA_OFS_STAT);
      wr(`EAA_OFS_MASK, 64'h3);
      rd(`EAA_OFS_STAT);
      wr(`EAA_OFS_STAT, 64'h2);
      rd(`EAA_OFS_STAT);
      wr(`EAA_OFS_STAT, 64'h1);
      rd(`EAA_OFS_STAT);
      for (int b = 0; b < 12; b++) begin
         wr(`EAA_OFS_CTRL, 64'(b % 2));
         wr(`EAA_OFS_MASK, 64'($urandom_range(3)));
         for (int i = 0; i < 32; i++) begin
            if (b == 0 || $urandom_range(3) == 0) wr(6'(i), {$urandom, $urandom});
         end
         wr(`EAA_OFS_FXE, 64'($urandom_range(7)) << 29);
         repeat (16) do_op($urandom_range(6), 1'($urandom), 1'($urandom), 5'($urandom),
                           5'($urandom), 5'($urandom));
         idle(2);
         rd(`EAA_OFS_FXE);
         rd(`EAA_OFS_CND);
         rd(`EAA_OFS_STAT);
         rd(6'($urandom_range(31)));
         wr(`EAA_OFS_STAT, 64'($urandom_range(3)));
      end
      give_verdict;
   end
endmodule
